// ---- logic/crc_pkg.sv ----
// Summary of operation
// - 16-bit mode: MSB first, polynomial 0x1021
// - 16-bit: byte XORed into accumulator upper byte
// - eight steps: top bit set, shift and XOR
// - 32-bit mode: reflected polynomial 0x04C11DB7
// - 32-bit: byte into low byte, right shifts
// - tested low bit one: XOR with 0xEDB88320
// - start value all zeros or all ones
// - polynomial select 0 is 32-bit, 1 is 16-bit
// - initial select 0 zeros, 1 ones
// - initialize write loads selected start value
// - each input byte write updates result automatically
// - auto: page, enable, then sector count
// - each auto sector supplies 512 bytes
// - control write in auto mode starts, stalls CPU
// - clear auto enable before reading result
// - result width 32 or 16 by select
// - byte pointer selects byte, increments per access
// - result holds until init, overwrite or input
package crc_pkg;
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_INPUT   = 8'h01;
	localparam logic [7:0]  ADDR_DATA    = 8'h02;
	localparam logic [7:0]  ADDR_AUTO    = 8'h03;
	localparam logic [7:0]  ADDR_COUNT   = 8'h04;
	localparam logic [7:0]  ADDR_BITREV  = 8'h05;
	localparam int          CTRL_SEL_BIT  = 4;
	localparam int          CTRL_INIT_BIT = 3;
	localparam int          CTRL_VAL_BIT  = 2;
	localparam int          CTRL_PTR_LSB  = 0;
	localparam int          AUTO_EN_BIT   = 7;
	localparam int          PAGE_W        = 6;
	localparam int          CNT_W         = 6;
	localparam int          SECT_SHIFT    = 9;
	localparam int          SECTOR_BYTES  = 512;
	localparam int          REM_W         = CNT_W + SECT_SHIFT;
	localparam logic [15:0] POLY16        = 16'h1021;
	localparam logic [31:0] POLY32        = 32'h04c11db7;
	localparam logic [31:0] POLY32_REFL   = 32'hedb88320;
	localparam logic [31:0] INIT_ZEROS    = 32'h00000000;
	localparam logic [31:0] INIT_ONES     = 32'hffffffff;
	localparam int          BIT_STEPS     = 8;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [7:0]  READ_ZERO     = 8'h00;

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_TAKE} crc_auto_st_t;
	typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_RESP} crc_host_st_t;
endpackage

// ---- logic/crc_if.sv ----
`timescale 1ns/10ps
interface crc_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       stall;

	modport dev
	(
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		output rdata,
		output stall
	);
	modport host
	(
		output addr,
		output wdata,
		output wr,
		output rd,
		input  rdata,
		input  stall
	);
endinterface

// ---- logic/crc_fifo.sv ----
`timescale 1ns/10ps
module crc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wptr_ff;
	logic [AW-1:0]    rptr_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;

	assign in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data  = mem_ff[rptr_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	always_ff @(posedge clk)
	begin
		if (push)
			mem_ff[wptr_ff] <= in_data;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wptr_ff  <= '0;
			rptr_ff  <= '0;
			count_ff <= '0;
		end
		else
		begin
			if (push)
				wptr_ff <= ptr_inc(wptr_ff);
			if (pop)
				rptr_ff <= ptr_inc(rptr_ff);
			if (push && !pop)
				count_ff <= count_ff + 1'b1;
			else if (pop && !push)
				count_ff <= count_ff - 1'b1;
		end
	end
endmodule

// ---- logic/crc_dev.sv ----
`timescale 1ns/10ps
module crc_dev
	import crc_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter int FLASH_AW   = 16
) (
	input  wire logic                REF_CLK,
	input  wire logic                SYS_RST,
	crc_if.dev                       BUS,
	output logic [FLASH_AW-1:0]      FLASH_ADDR,
	output logic                     FLASH_RD,
	input  wire logic [7:0]          FLASH_DATA,
	output logic                     AUTO_BUSY
);
	logic [31:0]       acc_ff;
	logic              sel16_ff;
	logic              val_ff;
	logic [1:0]        ptr_ff;
	logic              auto_en_ff;
	logic [PAGE_W-1:0] page_ff;
	logic [CNT_W-1:0]  count_ff;
	logic [7:0]        bitrev_ff;
	logic [7:0]        rdata_ff;
	logic [REM_W-1:0]  rem_ff;
	logic [FLASH_AW-1:0] faddr_ff;
	crc_auto_st_t      st_ff;

	logic        is_input;
	logic        other_acc;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_out_ready;
	logic [7:0]  fifo_out_data;
	logic        wr_ok;
	logic        rd_ok;
	logic        busy;
	logic        eng_valid;
	logic [7:0]  eng_byte;
	logic        ctrl_wr;
	logic        data_acc;
	logic        auto_start;
	logic [1:0]  nxt_ptr;

	// one 8-step byte update for either polynomial
	function automatic logic [31:0] crc_byte(input logic [31:0] acc,
		input logic [7:0] din, input logic sel16);
		logic [15:0] a16;
		logic [31:0] a32;
		a16 = acc[15:0] ^ {din, 8'h00};
		a32 = acc ^ {24'h000000, din};
		for (int i = 0; i < BIT_STEPS; i++)
		begin
			if (a16[15])
				a16 = {a16[14:0], 1'b0} ^ POLY16;
			else
				a16 = {a16[14:0], 1'b0};
			if (a32[0])
				a32 = {1'b0, a32[31:1]} ^ POLY32_REFL;
			else
				a32 = {1'b0, a32[31:1]};
		end
		// 16-bit mode leaves the upper half alone; a data read with the pointer set to 2 or 3 exposes it
		crc_byte = sel16 ? {acc[31:16], a16} : a32;
	endfunction

	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			rev8[i] = b[7-i];
	endfunction

	assign busy      = (st_ff != ST_IDLE);
	assign AUTO_BUSY = busy;
	assign is_input  = (BUS.addr == ADDR_INPUT);
	assign other_acc = (BUS.wr && !is_input) || BUS.rd;

	// non-input accesses wait for queued bytes so they see an up-to-date
	// result; input writes wait for room in the queue, and every access waits out an auto run
	always_comb
	begin
		BUS.stall = 1'b0;
		if (busy && (BUS.wr || BUS.rd))
			BUS.stall = 1'b1;
		else if (BUS.wr && is_input && !fifo_in_ready)
			BUS.stall = 1'b1;
		else if (other_acc && fifo_out_valid)
			BUS.stall = 1'b1;
	end

	assign wr_ok      = BUS.wr && !BUS.stall;
	assign rd_ok      = BUS.rd && !BUS.wr && !BUS.stall;
	assign ctrl_wr    = wr_ok && (BUS.addr == ADDR_CTRL);
	assign data_acc   = (wr_ok || rd_ok) && (BUS.addr == ADDR_DATA);
	assign auto_start = ctrl_wr && auto_en_ff && (count_ff != '0);

	assign fifo_out_ready = !busy;
	assign eng_valid = (st_ff == ST_TAKE) || (fifo_out_valid && !busy);
	assign eng_byte  = (st_ff == ST_TAKE) ? FLASH_DATA : fifo_out_data;

	crc_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) i_crc_fifo (
		.clk       (REF_CLK),
		.rst       (SYS_RST),
		// only an accepted write may push, so a held write never queues twice
		.in_valid  (wr_ok && is_input),
		.in_ready  (fifo_in_ready),
		.in_data   (BUS.wdata),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// wrap depends on the current result width
	always_comb
	begin
		if (sel16_ff && ptr_ff == 2'h1)
			nxt_ptr = 2'h0;
		else
			nxt_ptr = ptr_ff + 2'h1;
	end

	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			sel16_ff <= 1'b0;
			val_ff   <= 1'b0;
			ptr_ff   <= 2'h0;
		end
		else if (ctrl_wr)
		begin
			sel16_ff <= BUS.wdata[CTRL_SEL_BIT];
			val_ff   <= BUS.wdata[CTRL_VAL_BIT];
			ptr_ff   <= BUS.wdata[CTRL_PTR_LSB +: 2];
		end
		else if (data_acc)
			ptr_ff <= nxt_ptr;
	end

	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			acc_ff <= INIT_ZEROS;
		else if (ctrl_wr && BUS.wdata[CTRL_INIT_BIT])
			acc_ff <= BUS.wdata[CTRL_VAL_BIT] ? INIT_ONES
				: INIT_ZEROS;
		else if (data_acc && wr_ok)
			acc_ff[8*ptr_ff +: 8] <= BUS.wdata;
		else if (eng_valid)
			acc_ff <= crc_byte(acc_ff, eng_byte, sel16_ff);
	end

	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			auto_en_ff <= 1'b0;
			page_ff    <= '0;
			count_ff   <= '0;
			bitrev_ff  <= 8'h00;
		end
		else if (wr_ok)
		begin
			if (BUS.addr == ADDR_AUTO)
			begin
				auto_en_ff <= BUS.wdata[AUTO_EN_BIT];
				page_ff    <= BUS.wdata[PAGE_W-1:0];
			end
			else if (BUS.addr == ADDR_COUNT)
				count_ff <= BUS.wdata[CNT_W-1:0];
			else if (BUS.addr == ADDR_BITREV)
				bitrev_ff <= rev8(BUS.wdata);
		end
	end

	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			rdata_ff <= READ_ZERO;
		else if (rd_ok)
		begin
			if (BUS.addr == ADDR_CTRL)
				rdata_ff <= {3'h0, sel16_ff, 1'b0, val_ff, ptr_ff};
			else if (BUS.addr == ADDR_DATA)
				rdata_ff <= acc_ff[8*ptr_ff +: 8];
			else if (BUS.addr == ADDR_AUTO)
				rdata_ff <= {auto_en_ff, 1'b0, page_ff};
			else if (BUS.addr == ADDR_COUNT)
				rdata_ff <= {2'h0, count_ff};
			else if (BUS.addr == ADDR_BITREV)
				rdata_ff <= bitrev_ff;
			else
				rdata_ff <= READ_ZERO;
		end
	end
	assign BUS.rdata = rdata_ff;

	// two cycles per flash byte: address out, data back next edge
	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			st_ff    <= ST_IDLE;
			rem_ff   <= '0;
			faddr_ff <= '0;
		end
		else
		begin
			case (st_ff)
				ST_IDLE:
				begin
					if (auto_start)
					begin
						st_ff    <= ST_FETCH;
						rem_ff   <= REM_W'({count_ff, {SECT_SHIFT{1'b0}}});
						faddr_ff <= FLASH_AW'({page_ff, {SECT_SHIFT{1'b0}}});
					end
				end
				ST_FETCH:
					st_ff <= ST_TAKE;
				ST_TAKE:
				begin
					faddr_ff <= faddr_ff + 1'b1;
					rem_ff   <= rem_ff - 1'b1;
					st_ff    <= (rem_ff == REM_W'(1)) ? ST_IDLE : ST_FETCH;
				end
				default:
					st_ff <= ST_IDLE;
			endcase
		end
	end

	assign FLASH_ADDR = faddr_ff;
	assign FLASH_RD   = (st_ff == ST_FETCH);
endmodule

// ---- logic/crc_host.sv ----
`timescale 1ns/10ps
module crc_host
	import crc_pkg::*;
(
	input  wire logic       REF_CLK,
	input  wire logic       SYS_RST,
	crc_if.host             BUS,
	input  wire logic       CMD_VALID,
	input  wire logic       CMD_WRITE,
	input  wire logic [7:0] CMD_ADDR,
	input  wire logic [7:0] CMD_WDATA,
	output logic            CMD_READY,
	output logic            RSP_VALID,
	output logic [7:0]      RSP_DATA,
	output logic            WR_DONE
);
	crc_host_st_t st_ff;
	logic [7:0]   addr_ff;
	logic [7:0]   wdata_ff;
	logic         wr_ff;
	logic         rd_ff;
	logic         rsp_valid_ff;
	logic [7:0]   rsp_data_ff;
	logic         wr_done_ff;

	// the user sequences the auto-mode steps and clears the enable before
	// reading the result; this end only moves one access at a time
	assign CMD_READY = (st_ff == HS_IDLE);

	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			st_ff        <= HS_IDLE;
			addr_ff      <= 8'h00;
			wdata_ff     <= 8'h00;
			wr_ff        <= 1'b0;
			rd_ff        <= 1'b0;
			rsp_valid_ff <= 1'b0;
			rsp_data_ff  <= 8'h00;
			wr_done_ff   <= 1'b0;
		end
		else
		begin
			rsp_valid_ff <= 1'b0;
			wr_done_ff   <= 1'b0;
			case (st_ff)
				HS_IDLE:
				begin
					if (CMD_VALID)
					begin
						addr_ff  <= CMD_ADDR;
						wdata_ff <= CMD_WDATA;
						wr_ff    <= CMD_WRITE;
						rd_ff    <= !CMD_WRITE;
						st_ff    <= HS_REQ;
					end
				end
				HS_REQ:
				begin
					// hold the access while the device stalls
					if (!BUS.stall)
					begin
						wr_ff      <= 1'b0;
						rd_ff      <= 1'b0;
						wr_done_ff <= wr_ff;
						st_ff      <= rd_ff ? HS_RESP : HS_IDLE;
					end
				end
				HS_RESP:
				begin
					rsp_data_ff  <= BUS.rdata;
					rsp_valid_ff <= 1'b1;
					st_ff        <= HS_IDLE;
				end
				default:
					st_ff <= HS_IDLE;
			endcase
		end
	end

	assign BUS.addr  = addr_ff;
	assign BUS.wdata = wdata_ff;
	assign BUS.wr    = wr_ff;
	assign BUS.rd    = rd_ff;
	assign RSP_VALID = rsp_valid_ff;
	assign RSP_DATA  = rsp_data_ff;
	assign WR_DONE   = wr_done_ff;
endmodule

// ---- verif/crc_checker.sv ----
`timescale 1ns/10ps
module crc_checker
	import crc_pkg::*;
(
	input wire logic       REF_CLK,
	input wire logic       SYS_RST,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       stall
);
	wire        rtk = rd & ~wr & ~stall;
	wire        wtk = wr & ~stall;
	logic [7:0] rev_ff;
	logic [1:0] ptr_ff;
	logic       sel_ff;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	always_ff @(posedge REF_CLK or posedge SYS_RST)
		if (SYS_RST)
			rev_ff <= 8'h00;
		else if (wtk && addr == ADDR_BITREV)
			rev_ff <= {<<{wdata}};

	// shadow of the pointer, wrap point follows the last select written
	always_ff @(posedge REF_CLK or posedge SYS_RST)
		if (SYS_RST)
		begin
			ptr_ff <= 2'h0;
			sel_ff <= 1'b0;
		end
		else if (wtk && addr == ADDR_CTRL)
		begin
			ptr_ff <= wdata[1:0];
			sel_ff <= wdata[CTRL_SEL_BIT];
		end
		else if ((wtk || rtk) && addr == ADDR_DATA)
			ptr_ff <= (sel_ff && ptr_ff == 2'h1) ? 2'h0 : ptr_ff + 2'h1;

	sequence s_rd(logic [7:0] a);
		rtk && addr == a;
	endsequence

	property p_wr_hold;
		wr && stall |=> wr && $stable(addr) && $stable(wdata);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write dropped while stalled");
	property p_rd_hold;
		rd && !wr && stall |=> rd && $stable(addr);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read dropped while stalled");
	property p_rev;
		s_rd(ADDR_BITREV) |=> rdata == $past(rev_ff);
	endproperty
	a_rev: assert property (p_rev)
		else $error("bit reverse wrong");
	property p_in_zero;
		s_rd(ADDR_INPUT) |=> rdata == READ_ZERO;
	endproperty
	a_in_zero: assert property (p_in_zero)
		else $error("input register read not zero");
	property p_ptr;
		s_rd(ADDR_CTRL) |=> rdata[1:0] == $past(ptr_ff);
	endproperty
	a_ptr: assert property (p_ptr)
		else $error("byte pointer wrong");
	property p_sel;
		s_rd(ADDR_CTRL) |=> rdata[CTRL_SEL_BIT] == $past(sel_ff);
	endproperty
	a_sel: assert property (p_sel)
		else $error("select readback wrong");
	property p_rsv;
		s_rd(ADDR_CTRL) |=> rdata[7:5] == 3'h0 && !rdata[CTRL_INIT_BIT];
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("control read shows write-only bits");
	property p_hold;
		!rtk |=> $stable(rdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");
endmodule

// ---- verif/crc16_crc32_engine_tb.sv ----
`timescale 1ns/10ps
module crc16_crc32_engine_tb
	import crc_pkg::*;
;
	logic        ref_clk;
	logic        sys_rst     = 1'b1;
	logic        cmd_valid   = 1'b0;
	logic        cmd_write   = 1'b0;
	logic [7:0]  cmd_addr    = 8'h00;
	logic [7:0]  cmd_wdata   = 8'h00;
	logic [7:0]  flash_data  = 8'h00;
	logic        cmd_ready;
	logic        rsp_valid;
	logic [7:0]  rsp_data;
	logic        wr_done;
	logic [15:0] flash_addr;
	logic        flash_rd;
	logic        auto_busy;
	int          mismatches  = 0;
	int          comparisons = 0;
	int          busy_cycles = 0;

	crc_if bus ();
	crc_dev i_crc_dev (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS(bus.dev),
		.FLASH_ADDR(flash_addr), .FLASH_RD(flash_rd),
		.FLASH_DATA(flash_data), .AUTO_BUSY(auto_busy));
	crc_host i_crc_host (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
		.BUS(bus.host), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
		.CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready),
		.RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .WR_DONE(wr_done));
	crc_checker i_crc_checker (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
		.addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
		.rdata(bus.rdata), .stall(bus.stall));

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// flash answers one cycle after the fetch, garbage otherwise
	always @(posedge ref_clk)
		flash_data <= flash_rd ? flash_addr[7:0] ^ flash_addr[15:8]
			: ~flash_data;
	always @(posedge ref_clk)
		busy_cycles <= busy_cycles + int'(auto_busy === 1'b1);

	function automatic logic [31:0] upd(logic [31:0] acc, logic [7:0] b,
		logic s16);
		logic [31:0] a;
		a = s16 ? acc ^ {16'h0, b, 8'h0} : acc ^ {24'h0, b};
		for (int i = 0; i < BIT_STEPS; i++)
			if (s16)
				a[15:0] = a[15] ? (a[15:0] << 1) ^ POLY16 : a[15:0] << 1;
			else
				a = a[0] ? (a >> 1) ^ POLY32_REFL : a >> 1;
		return a;
	endfunction

	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	// the wait bound also covers a full single-sector flash run
	task automatic op(logic w, logic [7:0] a, logic [7:0] d,
		output logic [7:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr <= a;
		cmd_wdata <= d;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (cmd_ready !== 1'b1 && n < 4000);
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while ((w ? wr_done : rsp_valid) !== 1'b1 && n < 4000);
		if (n >= 4000)
		begin
			mismatches++;
			end_sim();
		end
		r = rsp_data;
	endtask

	task automatic bwr(logic [7:0] a, logic [7:0] d);
		logic [7:0] r;
		op(1'b1, a, d, r);
	endtask

	task automatic rd_res(int n, output logic [31:0] v);
		logic [7:0] r;
		v = '0;
		for (int i = 0; i < n; i++)
		begin
			op(1'b0, ADDR_DATA, 8'h00, r);
			v[8*i+:8] = r;
		end
	endtask

	task automatic t_crc(logic s16, logic one);
		logic [7:0]  din [4] = '{8'h00, 8'haa, 8'hbb, 8'hcc};
		logic [31:0] e;
		logic [31:0] v;
		e = one ? INIT_ONES : INIT_ZEROS;
		bwr(ADDR_CTRL, {3'h0, s16, 1'b1, one, 2'h0});
		foreach (din[i])
		begin
			bwr(ADDR_INPUT, din[i]);
			e = upd(e, din[i], s16);
		end
		rd_res(s16 ? 2 : 4, v);
		check(v, s16 ? {16'h0, e[15:0]} : e);
		rd_res(1, v);
		check(v, {24'h0, e[7:0]});
	endtask

	task automatic t_over();
		logic [31:0] v;
		logic [7:0]  r;
		bwr(ADDR_CTRL, 8'h10);
		bwr(ADDR_DATA, 8'h34);
		bwr(ADDR_DATA, 8'h12);
		rd_res(2, v);
		check(v, 32'h1234);
		// pointer must be back at byte 0 after four 16-bit accesses
		op(1'b0, ADDR_CTRL, 8'h00, r);
		check({24'h0, r}, 32'h00000010);
		bwr(ADDR_INPUT, 8'h63);
		rd_res(2, v);
		check(v, upd(32'h1234, 8'h63, 1'b1));
		// fixed reference point: one byte from an all-ones start
		bwr(ADDR_CTRL, 8'h1c);
		bwr(ADDR_INPUT, 8'h63);
		rd_res(2, v);
		check(v, 32'h0000bd35);
	endtask

	task automatic t_reg();
		logic [7:0] r;
		logic [7:0] e;
		logic [7:0] b [2] = '{8'h01, 8'ha6};
		foreach (b[i])
		begin
			bwr(ADDR_BITREV, b[i]);
			op(1'b0, ADDR_BITREV, 8'h00, r);
			e = {<<{b[i]}};
			check({24'h0, r}, {24'h0, e});
		end
		bwr(ADDR_CTRL, 8'h15);
		op(1'b0, ADDR_CTRL, 8'h00, r);
		check({24'h0, r}, 32'h00000015);
		op(1'b0, ADDR_INPUT, 8'h00, r);
		check({24'h0, r}, {24'h0, READ_ZERO});
	endtask

	task automatic t_auto();
		logic [31:0] e;
		logic [31:0] v;
		int          b0;
		e = INIT_ONES;
		for (int a = SECTOR_BYTES; a < 2 * SECTOR_BYTES; a++)
			e = upd(e, 8'(a) ^ 8'(a >> 8), 1'b0);
		bwr(ADDR_AUTO, 8'h81);
		bwr(ADDR_COUNT, 8'h01);
		b0 = busy_cycles;
		bwr(ADDR_CTRL, 8'h0c);
		bwr(ADDR_AUTO, 8'h00);
		check(busy_cycles - b0, 2 * SECTOR_BYTES);
		rd_res(4, v);
		check(v, e);
	endtask

	initial
	begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int k = 0; k < 4; k++)
			t_crc(k[1], k[0]);
		t_over();
		t_reg();
		t_auto();
		end_sim();
	end
endmodule
